// [logic/sgc_ctrl.sv]
// Host-side controller that issues sector protection commands to a
// parallel NOR flash over its asynchronous bus, ordered over APB.
// Assumes flash pins are synchronous to pclk and the flash keeps its
// own protection state; this block only sequences bus cycles.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "sgc_defs.svh"

module sgc_ctrl #(
    parameter int UNLOCK_CYC = `SGC_UNLOCK_CYC
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    output sgc_pkg::sgc_flash_out_s      flash_out,
    input  wire logic [31:0]             flash_dq_in,
    input  wire logic                    ready_busy_pin
);
    import sgc_pkg::*;

    logic [3:0]        cmd_reg;
    logic [21:0]       addr_reg;
    logic [63:0]       data_reg;
    logic              x32_reg;
    logic              busy_reg;
    logic              done_reg;
    logic              lock_reg;
    logic              unlock_ok_reg;
    logic              bad_reg;
    logic [31:0]       rdata_reg;
    sgc_state_e        state_reg;
    logic [11:0]       cnt_reg;
    logic [1:0]        part_reg;
    logic [1:0]        margin_reg;
    sgc_flash_out_s    fo_reg;
    sgc_op_e           op;
    logic              wr_en;
    logic              rd_en;
    logic              start;
    logic [1:0]        last_part;
    logic [31:0]       portion;

    assign op        = sgc_op_e'(cmd_reg);
    assign wr_en     = psel & penable & pwrite;
    assign rd_en     = psel & penable & ~pwrite;
    assign pready    = 1'b1;
    assign flash_out = fo_reg;
    // Portion count depends on bus width
    assign last_part = x32_reg ? 2'd1 : 2'd3;
    assign start     = wr_en && (paddr == `SGC_OFF_CMD) && !busy_reg;
    // Portions go low word first, which the password order expects
    always_comb begin
        case (part_reg)
            2'd0:    portion = x32_reg ? data_reg[31:0]
                                       : {16'h0000, data_reg[15:0]};
            2'd1:    portion = x32_reg ? data_reg[63:32]
                                       : {16'h0000, data_reg[31:16]};
            2'd2:    portion = {16'h0000, data_reg[47:32]};
            default: portion = {16'h0000, data_reg[63:48]};
        endcase
    end

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            case (paddr)
                `SGC_OFF_CMD, `SGC_OFF_ADDR, `SGC_OFF_DATA,
                `SGC_OFF_STATUS, `SGC_OFF_RDATA, `SGC_OFF_CFG:
                    pslverr = 1'b0;
                default: pslverr = 1'b1;
            endcase
        end
    end

    always_comb begin
        case (paddr)
            `SGC_OFF_CMD:    prdata = {28'h0000000, cmd_reg};
            `SGC_OFF_ADDR:   prdata = {10'h000, addr_reg};
            `SGC_OFF_DATA:   prdata = data_reg[31:0];
            `SGC_OFF_STATUS: prdata = {27'h0000000, bad_reg, unlock_ok_reg,
                                       lock_reg, done_reg, busy_reg};
            `SGC_OFF_RDATA:  prdata = rdata_reg;
            `SGC_OFF_CFG:    prdata = {31'h00000000, x32_reg};
            default:         prdata = 32'h00000000;
        endcase
    end

    // Software-written operands; frozen while a command runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg  <= 4'h0;
            addr_reg <= 22'h000000;
            data_reg <= 64'h0;
            x32_reg  <= 1'b1;
        end else if (wr_en && !busy_reg) begin
            case (paddr)
                `SGC_OFF_CMD:  cmd_reg <= pwdata[3:0];
                `SGC_OFF_ADDR: addr_reg <= pwdata[21:0];
                `SGC_OFF_DATA: data_reg <= {pwdata, data_reg[63:32]};
                `SGC_OFF_CFG:  x32_reg <= pwdata[`SGC_CFG_X32];
                default:       cmd_reg <= cmd_reg;
            endcase
        end
    end

    // Done, unlock and bad flags: a new start clears them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg      <= 1'b0;
            done_reg      <= 1'b0;
            bad_reg       <= 1'b0;
            unlock_ok_reg <= 1'b0;
            lock_reg      <= 1'b0;
            rdata_reg     <= 32'h00000000;
            state_reg     <= SGC_IDLE;
            cnt_reg       <= 12'h000;
            part_reg      <= 2'd0;
            margin_reg    <= 2'd0;
            fo_reg        <= '{addr: 22'h0, dq_out: 32'h0, dq_oe: 1'b0,
                               ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
        end else begin
            case (state_reg)
                SGC_IDLE: begin
                    if (start) begin
                        busy_reg   <= 1'b1;
                        done_reg   <= 1'b0;
                        bad_reg    <= 1'b0;
                        unlock_ok_reg <= 1'b0;
                        part_reg   <= 2'd0;
                        margin_reg <= 2'd0;
                        cnt_reg    <= 12'h000;
                        state_reg  <= SGC_WR;
                        case (sgc_op_e'(pwdata[3:0]))
                            SGC_OP_SECURE_PROT, SGC_OP_LOCK_SET,
                            SGC_OP_VOL_WRITE, SGC_OP_UNLOCK,
                            SGC_OP_NV_PROG, SGC_OP_NV_ERASE,
                            SGC_OP_LOCK_READ, SGC_OP_EXIT:
                                part_reg <= 2'd0;
                            default: begin
                                bad_reg   <= 1'b1;
                                busy_reg  <= 1'b0;
                                done_reg  <= 1'b1;
                                state_reg <= SGC_IDLE;
                            end
                        endcase
                    end
                end
                SGC_WR: begin
                    // Drive one write cycle, we_n low for a few clocks
                    fo_reg.ce_n  <= 1'b0;
                    fo_reg.oe_n  <= 1'b1;
                    fo_reg.dq_oe <= 1'b1;
                    fo_reg.we_n  <= (cnt_reg < 12'(`SGC_WE_CYC - 1))
                                    ? 1'b0 : 1'b1;
                    case (op)
                        SGC_OP_VOL_WRITE: begin
                            // Sector field high bits, 01h set or 00h clear
                            fo_reg.addr   <= {addr_reg[21:11], 11'h000};
                            fo_reg.dq_out <= {24'h000000, addr_reg[0]
                                             ? `SGC_CODE_SET : `SGC_CODE_CLEAR};
                        end
                        SGC_OP_NV_PROG: begin
                            // Erase select bit low selects program
                            fo_reg.addr   <= {addr_reg[21:11], 11'h000};
                            fo_reg.dq_out <= {24'h000000, `SGC_CODE_GUARD};
                        end
                        SGC_OP_NV_ERASE: begin
                            // Erase select bit high, sector ignored
                            fo_reg.addr   <= 22'h000040;
                            fo_reg.dq_out <= {24'h000000, `SGC_CODE_GUARD};
                        end
                        SGC_OP_UNLOCK: begin
                            fo_reg.addr   <= addr_reg;
                            fo_reg.dq_out <= portion;
                        end
                        SGC_OP_EXIT: begin
                            // Read/reset ends any protection command state
                            fo_reg.addr   <= 22'h000000;
                            fo_reg.dq_out <= {24'h000000, `SGC_CODE_RESET};
                        end
                        default: begin
                            // Secure protect, lock set, lock read
                            fo_reg.addr   <= addr_reg;
                            fo_reg.dq_out <= data_reg[31:0];
                        end
                    endcase
                    cnt_reg <= cnt_reg + 12'h001;
                    if (cnt_reg == 12'(`SGC_WE_CYC)) begin
                        fo_reg.ce_n  <= 1'b1;
                        fo_reg.dq_oe <= 1'b0;
                        cnt_reg      <= 12'h000;
                        case (op)
                            SGC_OP_UNLOCK:    state_reg <= SGC_WAIT;
                            SGC_OP_LOCK_READ: state_reg <= SGC_RD;
                            SGC_OP_NV_PROG, SGC_OP_NV_ERASE:
                                state_reg <= SGC_POLL;
                            default:          state_reg <= SGC_EXIT;
                        endcase
                    end
                end
                SGC_WAIT: begin
                    // Hold off the next portion for the window
                    cnt_reg <= cnt_reg + 12'h001;
                    if (cnt_reg >= 12'(UNLOCK_CYC - 1) && ready_busy_pin) begin
                        cnt_reg <= 12'h000;
                        if (part_reg == last_part) begin
                            // Confirm by reading the lock flag
                            state_reg <= SGC_RD;
                        end else begin
                            part_reg  <= part_reg + 2'd1;
                            state_reg <= SGC_WR;
                        end
                    end
                end
                SGC_POLL: begin
                    // Two margin check cycles; time-out shows as ready
                    if (ready_busy_pin) begin
                        margin_reg <= margin_reg + 2'd1;
                        if (margin_reg == 2'd1)
                            state_reg <= SGC_RD;
                    end
                end
                SGC_RD: begin
                    fo_reg.ce_n <= 1'b0;
                    fo_reg.oe_n <= 1'b0;
                    cnt_reg     <= cnt_reg + 12'h001;
                    if (cnt_reg == 12'(`SGC_WE_CYC)) begin
                        // Lock flag sits on the low data bit
                        rdata_reg   <= flash_dq_in;
                        lock_reg    <= flash_dq_in[0];
                        if (op == SGC_OP_UNLOCK)
                            unlock_ok_reg <= ~flash_dq_in[0];
                        fo_reg.ce_n <= 1'b1;
                        fo_reg.oe_n <= 1'b1;
                        cnt_reg     <= 12'h000;
                        state_reg   <= SGC_EXIT;
                    end
                end
                SGC_EXIT: begin
                    // Flash state effects on guards are the device's
                    busy_reg  <= 1'b0;
                    done_reg  <= 1'b1;
                    state_reg <= SGC_IDLE;
                end
                default: state_reg <= SGC_IDLE;
            endcase
        end
    end
endmodule // sgc_ctrl

// [logic/sgc_defs.svh]
// Constants for the sector guard controller: register offsets, fields,
// flash command codes and timing counts.
`ifndef SGC_DEFS_SVH
`define SGC_DEFS_SVH

`define SGC_OFF_CMD       12'h000
`define SGC_OFF_ADDR      12'h004
`define SGC_OFF_DATA      12'h008
`define SGC_OFF_STATUS    12'h00C
`define SGC_OFF_RDATA     12'h010
`define SGC_OFF_CFG       12'h014

`define SGC_ST_BUSY       0
`define SGC_ST_DONE       1
`define SGC_ST_LOCK       2
`define SGC_ST_UNLOCK_OK  3
`define SGC_ST_BAD_CMD    4

`define SGC_CFG_X32       0

`define SGC_CODE_RESET    8'hF0
`define SGC_CODE_GUARD    8'h60
`define SGC_CODE_SET      8'h01
`define SGC_CODE_CLEAR    8'h00

`define SGC_UNLOCK_NS     2000
`define SGC_CLK_NS        10
`define SGC_UNLOCK_CYC    ((`SGC_UNLOCK_NS + `SGC_CLK_NS - 1) / `SGC_CLK_NS)
`define SGC_WE_CYC        4
`define SGC_STATUS_MASK   32'h0000001F

`endif

// [logic/sgc_pkg.sv]
// Types shared by the sector guard controller.
// Assumes sgc_defs.svh is used for numeric constants.
package sgc_pkg;

typedef enum logic [3:0] {
    SGC_OP_NONE       = 4'h0,
    SGC_OP_SECURE_PROT = 4'h1,
    SGC_OP_LOCK_SET   = 4'h2,
    SGC_OP_VOL_WRITE  = 4'h3,
    SGC_OP_UNLOCK     = 4'h4,
    SGC_OP_NV_PROG    = 4'h5,
    SGC_OP_NV_ERASE   = 4'h6,
    SGC_OP_LOCK_READ  = 4'h7,
    SGC_OP_EXIT       = 4'h8
} sgc_op_e;

typedef enum logic [2:0] {
    SGC_IDLE  = 3'b000,
    SGC_WR    = 3'b001,
    SGC_WAIT  = 3'b010,
    SGC_RD    = 3'b011,
    SGC_EXIT  = 3'b100,
    SGC_POLL  = 3'b101
} sgc_state_e;

typedef struct packed {
    logic [21:0] addr;
    logic [31:0] dq_out;
    logic        dq_oe;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
} sgc_flash_out_s;

endpackage

// [verif/sgc_ctrl_checker.sv]
// Port checker for sgc_ctrl, bound onto every instance.
// Assumes zero-wait APB and a registered flash pin struct.
`timescale 1ns/1ns
module sgc_ctrl_checker #(
    parameter int UNLOCK_CYC = 200
) (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire sgc_pkg::sgc_flash_out_s flash_out,
    input wire logic [31:0]             flash_dq_in,
    input wire logic                    ready_busy_pin
);
    import sgc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_ready: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    a_bad_addr: assert property (psel && penable && paddr > 12'h014
        |-> pslverr) else $error("no pslverr");
    a_good_addr: assert property (psel && penable && paddr <= 12'h014
        && paddr[1:0] == 2'b00 |-> !pslverr) else $error("pslverr");
    a_we_frame: assert property (!flash_out.we_n |->
        !flash_out.ce_n && flash_out.dq_oe) else $error("bad frame");
    a_we_pulse: assert property ($fell(flash_out.we_n) |=>
        !flash_out.we_n [*2] ##1 flash_out.we_n) else $error("we len");
    a_we_stable: assert property (!flash_out.we_n && $past(!flash_out.we_n)
        |-> $stable(flash_out.addr) && $stable(flash_out.dq_out))
        else $error("write moved");
    a_oe_pulse: assert property ($fell(flash_out.oe_n) |=>
        !flash_out.oe_n [*3] ##1 flash_out.oe_n) else $error("oe len");
    a_no_fight: assert property (!flash_out.oe_n |->
        !flash_out.dq_oe && !flash_out.ce_n) else $error("dq fight");
    a_write_ready: assert property ($fell(flash_out.we_n) |->
        ready_busy_pin) else $error("write while busy");
endmodule // sgc_ctrl_checker

bind sgc_ctrl sgc_ctrl_checker #(.UNLOCK_CYC(UNLOCK_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_out(flash_out),
    .flash_dq_in(flash_dq_in), .ready_busy_pin(ready_busy_pin));

// [verif/sgc_flash_model.sv]
// Behavioural flash device: guard bits, lock flag, password unlock.
// Assumes pins synchronous to clk; command codes are bench-chosen.
`timescale 1ns/1ns
module sgc_flash_model #(
    parameter logic [7:0]  LOCK_CODE = 8'h5A,
    parameter logic [7:0]  SEC_CODE  = 8'hA5,
    parameter logic [7:0]  STAT_CODE = 8'h3C,
    parameter logic [63:0] PASSWORD  = 64'h0,
    parameter logic        PW_MODE   = 1'b0,
    parameter int          BUSY_CYC  = 4,
    parameter int          TMO_CYC   = 12
) (
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire sgc_pkg::sgc_flash_out_s fo,
    output logic [31:0]                 dq,
    output logic                        ry
);
    import sgc_pkg::*;
    logic [2047:0] nv = '0, vol, guarded;
    logic [31:0]   wa, wd, last = 32'h0;
    logic [63:0]   pw;
    logic          lock, sec_prot = 1'b0, tmo, we_q, oe_q, tog;
    logic          en = 1'b1; // Command decoding never disabled here
    int            busy, ign, part;
    wire  [10:0]   sec = wa[21:11];
    assign guarded = nv | vol;
    assign ry = (busy == 0);
    // Released bus shows inverted last value, never a stale match
    assign dq = (!fo.oe_n && !fo.ce_n) ?
        (busy != 0 ? 32'(tog) << 6 : 32'(lock)) : ~last;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vol <= '0;
            lock <= PW_MODE;
            {busy, part, ign} <= '0;
            {tmo, tog, we_q, oe_q} <= 4'h3;
        end else begin
            we_q <= fo.we_n;
            oe_q <= fo.oe_n;
            if (busy != 0) busy <= busy - 1;
            if (!fo.oe_n) last <= dq;
            if (oe_q && !fo.oe_n) tog <= ~tog;
            if (!fo.ce_n && !fo.we_n) begin
                wa <= 32'(fo.addr);
                wd <= fo.dq_out;
            end
            if (fo.we_n && !we_q && en) begin
                tmo <= 1'b0;
                case (wd[7:0])
                8'hF0: part <= 0;
                8'h60: if (lock && (wa[6] || nv[sec])) begin
                    busy <= TMO_CYC;
                    tmo <= 1'b1;
                end else begin
                    busy <= BUSY_CYC;
                    if (wa[6]) nv <= '0;
                    else nv[sec] <= 1'b1;
                end
                8'h01, 8'h00: vol[sec] <= wd[0];
                LOCK_CODE: begin
                    lock <= 1'b1;
                    vol <= nv;
                end
                SEC_CODE: sec_prot <= 1'b1;
                STAT_CODE: ;
                default: if (busy != 0) ign <= ign + 1;
                else begin
                    pw <= {wd, pw[63:32]};
                    busy <= BUSY_CYC;
                    part <= (part == 1) ? 0 : part + 1;
                    if (part == 1 && {wd, pw[63:32]} == PASSWORD)
                        lock <= 1'b0;
                end
                endcase
            end
        end
    end
endmodule // sgc_flash_model

// [verif/tb_sgc_ctrl.sv]
// Self-checking bench for sgc_ctrl facing the flash model.
// Assumes UNLOCK_CYC shortened to 5 and model default codes.
`timescale 1ns/1ns
`include "sgc_defs.svh"
module tb_sgc_ctrl;
    import sgc_pkg::*;
    localparam logic [63:0] PW = 64'h1357_9BDF_2468_ACE0;
    localparam logic [10:0] S1 = 11'h005;
    localparam logic [10:0] S2 = 11'h123;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, dq, st, r;
    logic        pready, pslverr, ry, e;
    sgc_flash_out_s fo;
    int          errors = 0, num_checks = 0;
    always #5 pclk = ~pclk;
    sgc_ctrl #(.UNLOCK_CYC(5)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_out(fo), .flash_dq_in(dq),
        .ready_busy_pin(ry));
    sgc_flash_model #(.PASSWORD(PW)) flash (.clk(pclk), .rst_n(presetn),
        .fo(fo), .dq(dq), .ry(ry));
    task automatic chk(string n, logic [31:0] s, logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            errors++;
            $display("BAD %s exp %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        logic rdy;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Answer and read data are taken at the edge that sees pready high
        do begin
            @(posedge pclk);
            {rdy, rd, er} = {pready, prdata, pslverr};
        end while (rdy !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic op(logic [3:0] c, logic [31:0] a, logic [63:0] d);
        int n = 0;
        apb(1'b1, `SGC_OFF_ADDR, a, r, e);
        apb(1'b1, `SGC_OFF_DATA, d[31:0], r, e);
        apb(1'b1, `SGC_OFF_DATA, d[63:32], r, e);
        apb(1'b1, `SGC_OFF_CMD, {28'h0, c}, r, e);
        do begin
            apb(1'b0, `SGC_OFF_STATUS, 32'h0, st, e);
            n++;
        end while (st[`SGC_ST_BUSY] !== 1'b0 && n < 3000);
        chk("done", 32'(st[`SGC_ST_DONE]), 32'h1);
    endtask
    task automatic t_regs;
        apb(1'b0, `SGC_OFF_CFG, 32'h0, r, e);
        chk("cfg", r, 32'h1);
        apb(1'b0, `SGC_OFF_STATUS, 32'h0, r, e);
        chk("status", r, 32'h0);
        apb(1'b0, 12'h018, 32'h0, r, e);
        chk("slverr", 32'(e), 32'h1);
        chk("vol", 32'(|flash.vol), 32'h0);
    endtask
    task automatic t_vol;
        op(4'h3, {10'h0, S1, 11'h001}, 64'h0);
        chk("vol set", 32'(flash.vol[S1]), 32'h1);
        chk("wr sec", 32'(flash.wa[21:11]), 32'(S1));
        chk("guard", 32'(flash.guarded[S1]), 32'h1);
        op(4'h3, {10'h0, S1, 11'h000}, 64'h0);
        chk("vol clr", 32'(flash.vol[S1]), 32'h0);
        op(4'h8, 32'h0, 64'h0);
        chk("exit", 32'(flash.wd[7:0]), 32'h000000F0);
    endtask
    task automatic t_lock;
        op(4'h5, {10'h0, S2, 11'h000}, 64'h0);
        chk("nv prog", 32'(flash.nv[S2]), 32'h1);
        op(4'h2, 32'h0, 64'h5A);
        chk("lock", 32'(flash.lock), 32'h1);
        chk("copy", 32'(flash.vol[S2]), 32'h1);
        op(4'h7, 32'h0, 64'h3C);
        chk("lock rd", 32'(st[`SGC_ST_LOCK]), 32'h1);
        op(4'h3, {10'h0, S1, 11'h001}, 64'h0);
        chk("vol any", 32'(flash.vol[S1]), 32'h1);
        op(4'h5, {10'h0, S2, 11'h000}, 64'h0);
        chk("prog tmo", 32'(flash.tmo), 32'h1);
        op(4'h6, 32'h0, 64'h0);
        chk("ers tmo", 32'(flash.tmo), 32'h1);
        chk("kept", 32'(flash.nv[S2]), 32'h1);
    endtask
    task automatic t_unlock;
        op(4'h4, 32'h0, PW ^ 64'h0000_0001_0000_0000);
        chk("bad pw", 32'(st[`SGC_ST_UNLOCK_OK]), 32'h0);
        chk("still", 32'(flash.lock), 32'h1);
        op(4'h4, 32'h0, PW);
        chk("unlock", 32'(st[`SGC_ST_UNLOCK_OK]), 32'h1);
        chk("lock clr", 32'(st[`SGC_ST_LOCK]), 32'h0);
        chk("spacing", 32'(flash.ign), 32'h0);
    endtask
    task automatic t_misc;
        op(4'h6, 32'h0, 64'h0);
        chk("erase", 32'(|flash.nv), 32'h0);
        op(4'h1, 32'h0, 64'hA5);
        chk("secure", 32'(flash.sec_prot), 32'h1);
        op(4'h9, 32'h0, 64'h0);
        chk("bad op", 32'(st[`SGC_ST_BAD_CMD]), 32'h1);
        op(4'h2, 32'h0, 64'h5A);
        op(4'h3, {10'h0, S1, 11'h001}, 64'h0);
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk("rst lock", 32'(flash.lock), 32'h0);
        chk("rst vol", 32'(|flash.vol), 32'h0);
    endtask
    task automatic summarize;
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_vol();
        t_lock();
        t_unlock();
        t_misc();
        summarize();
    end
    initial begin
        #400_000;
        errors++;
        summarize();
    end
endmodule // tb_sgc_ctrl
